// [verilog/umc_pkg.sv]
// Constants for the modem control, modem status and baud generator block
//
// Contract
// - Terminal-ready bit set drives its output low, clear drives it high.
// - Request-send bit set drives its output low, clear high, unless autoflow rules.
// - User output A is storage only; in loopback it feeds the ring status.
// - User output B set enables the channel interrupt output.
// - Loopback holds serial out high, ignores serial in, loops transmit into receive.
// - Loopback ignores modem pins, forces outputs high, routes control bits to status.
// - Loopback interrupts come only from control bit writes, not pins.
// - Autoflow and request-send bits select auto-RTS/CTS, auto-CTS only, or none.
// - The two top control bits read zero and ignore writes.
// - Input changes set delta bits; status read clears all delta bits.
// - Upper status bits show the complement of the four modem inputs.
// - Enabled status interrupt fires when any low status bit is set, except the CTS delta bit under auto-CTS, lowest priority.
// - Under auto-CTS a CTS change sets its delta bit but raises no interrupt.
// - Ring edge bit sets only on ring input low-to-high.
// - Status read clears only the four delta bits, not the live bits.
// - Status arising during a status read waits for the read's trailing edge.
// - A set bit whose condition recurs during the read clears at the trailing edge.
// - Baud divisor is 16 bits from two 8-bit latches, values 1 to 65535.
// - Writing either divisor latch reloads the baud counter at once.
// - Baud output and receive sampling run at reference over divisor, 16x bit rate.
// - Divisor access bit selects latches versus data and interrupt enable.
package umc_pkg;
  localparam logic [2:0] ADDR_DIV_LOW  = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_INT_EN   = 3'h1;
  localparam logic [2:0] ADDR_LINE_CTL = 3'h3;
  localparam logic [2:0] ADDR_MODEM    = 3'h4;
  localparam logic [2:0] ADDR_STATUS   = 3'h6;
  localparam int BIT_DTR  = 0;
  localparam int BIT_RTS  = 1;
  localparam int BIT_OUTA = 2;
  localparam int BIT_OUTB = 3;
  localparam int BIT_LOOP = 4;
  localparam int BIT_AFE  = 5;
  localparam int BIT_DIV_ACCESS = 7;
  localparam int BIT_MSI_EN     = 3;
  localparam logic [7:0] MODEM_WR_MASK = 8'h3F;
  localparam logic [7:0] RST_MODEM     = 8'h00;
  localparam logic [7:0] RST_LINE_CTL  = 8'h00;
  localparam logic [3:0] RST_INT_EN    = 4'h0;
  localparam logic [7:0] RST_DIV_BYTE  = 8'h00;
  localparam logic [15:0] RST_COUNT    = 16'h0000;
  localparam logic [15:0] COUNT_TERM   = 16'h0001;
endpackage

// [verilog/umc_top.sv]
// Modem control, modem status and baud generator of one serial channel
`timescale 1ns/100ps
module umc_top
  import umc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Parallel register port
  input  wire logic       cs_i,
  input  wire logic [2:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // Modem pins
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       ri_n_i,
  input  wire logic       dcd_n_i,
  output logic            dtr_n_o,
  output logic            rts_n_o,
  // Serial path
  input  wire logic       serial_rx_in_i,
  input  wire logic       transmit_shift_reg_i,
  output logic            serial_tx_out_o,
  output logic            receive_shift_reg_o,
  // Channel logic links
  input  wire logic       rx_fifo_hold_i,
  input  wire logic       chan_irq_i,
  output logic            irq_o,
  output logic            msi_req_o,
  output logic            auto_cts_o,
  output logic            auto_rts_o,
  output logic            baud16_o
);

  logic [7:0]  modem_control;
  logic [7:0]  line_ctl;
  logic [3:0]  interrupt_enable_reg;
  logic [7:0]  div_low;
  logic [7:0]  divisor_high_latch;
  logic [15:0] baud_cnt;
  logic [3:0]  delta;
  logic [3:0]  pend;
  logic [3:0]  live_q;
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic [4:0]  sync3;
  logic [4:0]  filt;
  logic        st_rd_q;

  logic        wr_go;
  logic        rd_go;
  logic        divisor_access_bit;
  logic        loop;
  logic        st_rd;
  logic        st_trail;
  logic        div_wr;
  logic [15:0] divisor;
  logic [3:0]  live;
  logic [3:0]  ev;
  logic        auto_rts;
  logic        auto_cts;
  logic [7:0]  next_rdata;

  assign wr_go    = cs_i & wr_i;
  assign rd_go    = cs_i & rd_i;
  assign divisor_access_bit     = line_ctl[BIT_DIV_ACCESS];
  assign loop     = modem_control[BIT_LOOP];
  assign st_rd    = rd_go & (addr_i == ADDR_STATUS);
  assign st_trail = st_rd_q & ~st_rd;
  assign div_wr   = wr_go & divisor_access_bit & ((addr_i == ADDR_DIV_LOW) | (addr_i == ADDR_DIV_HIGH));
  assign divisor  = {divisor_high_latch, div_low};

  // Flow mode select
  assign auto_rts = modem_control[BIT_AFE] & modem_control[BIT_RTS];
  assign auto_cts = modem_control[BIT_AFE];

  // Pin synchronisers, bits: 0 cts, 1 dsr, 2 ri, 3 dcd, 4 serial in
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
      sync3 <= 5'h1F;
    end
    else
    begin
      sync1 <= {serial_rx_in_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_filt
      always_ff @(posedge clk_sys_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          filt[gi] <= 1'b1;
        else if (sync2[gi] == sync3[gi])
          filt[gi] <= sync3[gi];
      end
    end
  endgenerate

  // Live status: cts, dsr, ri, dcd
  assign live = loop ? {modem_control[BIT_OUTB], modem_control[BIT_OUTA],
                        modem_control[BIT_DTR], modem_control[BIT_RTS]}
                     : ~filt[3:0];
  assign ev   = {live[3] ^ live_q[3],
                 live_q[2] & ~live[2],
                 live[1] ^ live_q[1],
                 live[0] ^ live_q[0]};

  // Register writes
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      modem_control        <= RST_MODEM;
      line_ctl             <= RST_LINE_CTL;
      interrupt_enable_reg <= RST_INT_EN;
      div_low              <= RST_DIV_BYTE;
      divisor_high_latch   <= RST_DIV_BYTE;
    end
    else if (wr_go)
    begin
      case (addr_i)
        ADDR_DIV_LOW:
          if (divisor_access_bit)
            div_low <= wdata_i;
        ADDR_DIV_HIGH:
          if (divisor_access_bit)
            divisor_high_latch <= wdata_i;
          else
            interrupt_enable_reg <= wdata_i[3:0];
        ADDR_LINE_CTL:
          line_ctl <= wdata_i;
        ADDR_MODEM:
          modem_control <= wdata_i & MODEM_WR_MASK;
        default:
          line_ctl <= line_ctl;
      endcase
    end
  end

  // Read data
  always_comb
  begin
    next_rdata = 8'h00;
    case (addr_i)
      ADDR_DIV_LOW:  next_rdata = divisor_access_bit ? div_low : 8'h00;
      ADDR_DIV_HIGH: next_rdata = divisor_access_bit ? divisor_high_latch : {4'h0, interrupt_enable_reg};
      ADDR_LINE_CTL: next_rdata = line_ctl;
      ADDR_MODEM:    next_rdata = modem_control & MODEM_WR_MASK;
      ADDR_STATUS:   next_rdata = {live_q, delta};
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (rd_go)
      rdata_o <= next_rdata;
  end

  // Status tracking and delta bits
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      live_q  <= 4'h0;
      delta   <= 4'h0;
      pend    <= 4'h0;
      st_rd_q <= 1'b0;
    end
    else
    begin
      live_q  <= live;
      st_rd_q <= st_rd;
      if (st_rd)
      begin
        pend  <= pend | ev;
        delta <= delta;
      end
      else if (st_trail)
      begin
        pend  <= 4'h0;
        delta <= (pend | ev) & ~delta;
      end
      else
        delta <= delta | ev;
    end
  end

  // Pins and interrupt outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dtr_n_o             <= 1'b1;
      rts_n_o             <= 1'b1;
      serial_tx_out_o     <= 1'b1;
      receive_shift_reg_o <= 1'b1;
      irq_o               <= 1'b0;
      msi_req_o           <= 1'b0;
      auto_cts_o          <= 1'b0;
      auto_rts_o          <= 1'b0;
    end
    else
    begin
      dtr_n_o <= loop | ~modem_control[BIT_DTR];
      rts_n_o <= loop | (auto_rts ? rx_fifo_hold_i : ~modem_control[BIT_RTS]);
      serial_tx_out_o     <= loop | transmit_shift_reg_i;
      receive_shift_reg_o <= loop ? transmit_shift_reg_i : filt[4];
      irq_o      <= modem_control[BIT_OUTB] & chan_irq_i;
      msi_req_o  <= interrupt_enable_reg[BIT_MSI_EN] &
                    (|delta[3:1] | (delta[0] & ~auto_cts));
      auto_cts_o <= auto_cts;
      auto_rts_o <= auto_rts;
    end
  end

  // Baud counter, one pulse per divisor cycles
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      baud_cnt <= RST_COUNT;
      baud16_o <= 1'b0;
    end
    else if (div_wr)
    begin
      baud_cnt <= (addr_i == ADDR_DIV_LOW) ? {divisor_high_latch, wdata_i}
                                           : {wdata_i, div_low};
      baud16_o <= 1'b0;
    end
    else if (baud_cnt <= COUNT_TERM)
    begin
      baud_cnt <= divisor;
      baud16_o <= (divisor != RST_COUNT);
    end
    else
    begin
      baud_cnt <= baud_cnt - COUNT_TERM;
      baud16_o <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_DTR_LEVEL: assert property (!loop |=> dtr_n_o == !$past(modem_control[BIT_DTR]))
    else $error("terminal ready pin wrong");
  AST_RTS_LEVEL: assert property ((!loop && !auto_rts) |=> rts_n_o == !$past(modem_control[BIT_RTS]))
    else $error("request send pin wrong");
  AST_LOOP_PINS: assert property (loop |=> (dtr_n_o && rts_n_o && serial_tx_out_o))
    else $error("loopback pins not high");
  AST_LOOP_DATA: assert property (loop |=> receive_shift_reg_o == $past(transmit_shift_reg_i))
    else $error("loopback data path broken");
  AST_LOOP_LIVE: assert property (loop |=> live_q[1] == $past(modem_control[BIT_DTR]))
    else $error("loopback dsr routing wrong");
  AST_MODEM_TOP: assert property ((rd_go && addr_i == ADDR_MODEM) |=> rdata_o[7:6] == 2'b00)
    else $error("modem control top bits nonzero");
  AST_READ_HOLD: assert property (st_rd |=> $stable(delta))
    else $error("delta changed during read");
  AST_READ_CLEAR: assert property ((st_trail && ev == 4'h0 && pend == 4'h0) |=> delta == 4'h0)
    else $error("delta not cleared by read");
  AST_CTS_NO_IRQ: assert property ((auto_cts && delta[3:1] == 3'b000) |=> !msi_req_o)
    else $error("auto cts raised interrupt");
  AST_MSI_FIRE: assert property ((interrupt_enable_reg[BIT_MSI_EN] && delta[3]) |=> msi_req_o)
    else $error("status interrupt missing");
  AST_RING_FALL: assert property ((!st_rd && !st_trail && live[2] && !live_q[2]) |=>
                                  delta[2] == $past(delta[2]))
    else $error("ring edge set on wrong edge");
  AST_DIV_RELOAD: assert property ((div_wr && addr_i == ADDR_DIV_HIGH) |=>
                                   baud_cnt == {$past(wdata_i), div_low})
    else $error("counter not reloaded");
  AST_DIV_ONE: assert property ((divisor == COUNT_TERM && !div_wr) [*2] |=> baud16_o)
    else $error("divide by one not continuous");
  AST_IRQ_GATE: assert property (!modem_control[BIT_OUTB] |=> !irq_o)
    else $error("interrupt passed while disabled");
  AST_TRAIL_SET: assert property ((st_trail && delta == 4'h0) |=> delta == $past(pend | ev))
    else $error("event during read not applied");
  AST_RECUR_CLEAR: assert property (st_trail |=> (delta & $past(delta)) == 4'h0)
    else $error("set bit not cleared at read end");
  AST_LIVE_PINS: assert property (!loop |=> live_q == ~$past(filt[3:0]))
    else $error("live status not pin complement");
  AST_BAUD_DOWN: assert property ((!div_wr && baud_cnt > COUNT_TERM) |=>
                                  (baud_cnt == $past(baud_cnt) - COUNT_TERM) && !baud16_o)
    else $error("baud counter not counting down");
  AST_BAUD_PULSE: assert property ((!div_wr && baud_cnt == COUNT_TERM && |divisor) |=>
                                   (baud16_o && baud_cnt == $past(divisor)))
    else $error("baud terminal count missed");

endmodule

// [sim/umc_modem_model.sv]
// Modem partner model driving the four status lines
`timescale 1ns/100ps
module umc_modem_model
(
  // Clock and requested line levels {dcd, ri, dsr, cts}
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] want_n_i,
  // Modem status lines, active low
  output logic            cts_n_o,
  output logic            dsr_n_o,
  output logic            ri_n_o,
  output logic            dcd_n_o
);
  initial {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = 4'hF;
  // Lines change just after a clock edge
  always @(posedge clk_sys_i)
  begin
    {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} <= want_n_i;
  end
endmodule

// [sim/test_uart_modem_ctrl_status_baud.sv]
// Self-checking bench for the modem control, status and baud block
`timescale 1ns/100ps
module test_uart_modem_ctrl_status_baud;
  import umc_pkg::*;
  typedef struct {logic [7:0] wd; logic [7:0] rb; logic [4:0] o;} umc_row_t;
  logic       clk_sys_i, rst_n_i, cs, wr, rd, transmit_shift_reg, srx, hold, cirq;
  logic [2:0] addr;
  logic [7:0] wd, rdata, v;
  logic [3:0] want_n;
  logic       cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, txo, receive_shift_reg, irq, msi, acts, arts, b16;
  int         fails, n_checks, cyc, n;
  logic [15:0] divs [3] = '{16'h0001, 16'h0003, 16'h0105};
  // Modem control value, readback, {dtr_n, rts_n, auto_cts, auto_rts, irq}
  umc_row_t   rows [6] = '{'{8'h00, 8'h00, 5'b11000}, '{8'h01, 8'h01, 5'b01000},
    '{8'h02, 8'h02, 5'b10000}, '{8'h23, 8'h23, 5'b00110}, '{8'h21, 8'h21, 5'b01100},
    '{8'hCC, 8'h0C, 5'b11001}};

  umc_modem_model modem (.clk_sys_i(clk_sys_i), .want_n_i(want_n), .cts_n_o(cts_n),
    .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n));
  umc_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_i(cs), .addr_i(addr), .wr_i(wr),
    .rd_i(rd), .wdata_i(wd), .rdata_o(rdata), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
    .ri_n_i(ri_n), .dcd_n_i(dcd_n), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
    .serial_rx_in_i(srx), .transmit_shift_reg_i(transmit_shift_reg), .serial_tx_out_o(txo),
    .receive_shift_reg_o(receive_shift_reg), .rx_fifo_hold_i(hold), .chan_irq_i(cirq), .irq_o(irq),
    .msi_req_o(msi), .auto_cts_o(acts), .auto_rts_o(arts), .baud16_o(b16));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask

  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    cs = 1'b1; wr = 1'b1; addr = a; wd = d;
    tick(1);
    cs = 1'b0; wr = 1'b0;
    tick(1);
  endtask

  task automatic rdr(input logic [2:0] a, output logic [7:0] d);
    cs = 1'b1; rd = 1'b1; addr = a;
    tick(1);
    d = rdata;
    cs = 1'b0; rd = 1'b0;
    tick(1);
  endtask

  task automatic pins(input logic [3:0] w);
    want_n = w;
    tick(10);
  endtask

  task automatic gap(output int k);
    k = 0;
    do
    begin
      tick(1);
      k++;
    end while (b16 !== 1'b1 && k < 5000);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  initial
  begin
    rst_n_i = 1'b0; cs = 1'b0; wr = 1'b0; rd = 1'b0; addr = 3'h0; wd = 8'h00; transmit_shift_reg = 1'b1;
    srx = 1'b1; hold = 1'b0; cirq = 1'b1; want_n = 4'hF; fails = 0; n_checks = 0; cyc = 0;
    tick(16);
    chk({dtr_n, rts_n, txo, b16}, 16'h000E);
    rst_n_i = 1'b1;
    rdr(ADDR_STATUS, v);
    chk(v, 16'h0000);
    $display("reset test done");
    foreach (rows[i])
    begin
      wrr(ADDR_MODEM, rows[i].wd);
      tick(3);
      rdr(ADDR_MODEM, v);
      chk(v, rows[i].rb);
      chk({dtr_n, rts_n, acts, arts, irq}, rows[i].o);
    end
    $display("control table done");
    wrr(ADDR_MODEM, 8'h00);
    wrr(ADDR_INT_EN, 8'h08);
    pins(4'hE);
    chk(msi, 1'b1);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h0011);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h0010);
    chk(msi, 1'b0);
    pins(4'hA);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h0050);
    pins(4'h4);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h00BE);
    wrr(ADDR_MODEM, 8'h20);
    pins(4'h5);
    chk(msi, 1'b0);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h00A1);
    $display("modem status test done");
    wrr(ADDR_MODEM, 8'h1F);
    transmit_shift_reg = 1'b0;
    tick(6);
    chk({dtr_n, rts_n, txo, receive_shift_reg}, 16'h000E);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h00F1);
    pins(4'hA);
    chk(msi, 1'b0);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h00F0);
    wrr(ADDR_MODEM, 8'h10);
    tick(6);
    chk(msi, 1'b1);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h000F);
    wrr(ADDR_MODEM, 8'h00);
    tick(3);
    chk(txo, 1'b0);
    chk(receive_shift_reg, 1'b1);
    srx = 1'b0;
    tick(6);
    chk(receive_shift_reg, 1'b0);
    $display("loopback test done");
    cs = 1'b1; rd = 1'b1; addr = ADDR_STATUS; want_n = 4'h9;
    tick(10);
    chk(rdata, 8'h61);
    cs = 1'b0; rd = 1'b0;
    tick(1);
    rdr(ADDR_STATUS, v);
    chk(v, 16'h0062);
    $display("read inhibit test done");
    wrr(ADDR_LINE_CTL, 8'h80);
    foreach (divs[i])
    begin
      wrr(ADDR_DIV_HIGH, divs[i][15:8]);
      wrr(ADDR_DIV_LOW, divs[i][7:0]);
      gap(n);
      gap(n);
      chk(n[15:0], divs[i]);
    end
    wrr(ADDR_DIV_HIGH, 8'h00);
    gap(n);
    chk(n[15:0], 16'h0004);
    gap(n);
    chk(n[15:0], 16'h0005);
    wrr(ADDR_LINE_CTL, 8'h00);
    $display("baud test done");
    wrr(ADDR_MODEM, 8'h03);
    tick(2);
    rst_n_i = 1'b0;
    tick(2);
    chk({dtr_n, rts_n, txo, b16, msi}, 16'h001C);
    rst_n_i = 1'b1;
    rdr(ADDR_MODEM, v);
    chk(v, 16'h0000);
    chk(b16, 1'b0);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule
